// >>> verilog/sdrbr_map.svh
// constants for the sdram row/burst/refresh controller
`ifndef SDRBR_MAP_SVH
`define SDRBR_MAP_SVH
// software register offsets (word addresses on the plain port)
`define SDRBR_REG_CTRL     4'h0
`define SDRBR_REG_CMD      4'h1
`define SDRBR_REG_ADDR     4'h2
`define SDRBR_REG_STATUS   4'h3
`define SDRBR_REG_BANKS    4'h4
`define SDRBR_REG_REFCNT   4'h5
// control register fields
`define SDRBR_CTRL_REFEN   0
`define SDRBR_CTRL_WLEXIT  1
`define SDRBR_CTRL_AL_LO   4
`define SDRBR_CTRL_CL_LO   8
`define SDRBR_CTRL_BLF_LO  12
`define SDRBR_CTRL_RESET   32'h0000_0500
// mode register and command address bit positions
`define SDRBR_MR1_LEVEL    7
`define SDRBR_ADDR_BURST   12
// timing figures in ns, converted to 8 ns cycles; the ones ending in CK are already in cycles
`define SDRBR_CLK_NS       8
`define SDRBR_TRP_NS       14
`define SDRBR_TRFC_NS      260
`define SDRBR_TMRD_CK      4
`define SDRBR_TMOD_CK      12
`define SDRBR_TIS_CK       1
`define SDRBR_TREFI_NS     7800
`define SDRBR_CYC_UP(ns)   (((ns) + `SDRBR_CLK_NS - 1) / `SDRBR_CLK_NS)
`define SDRBR_CYC_DN(ns)   ((ns) / `SDRBR_CLK_NS)
`define SDRBR_TCCD_CK      4
`define SDRBR_MAX_POSTPONE 8
`define SDRBR_MAX_PULLIN   8
`endif

// >>> verilog/sdrbr_pkg.sv
// types for the sdram row/burst/refresh controller
package sdrbr_pkg;
  // device command opcode {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDRBR_NOP = 4'b0111,
    SDRBR_ACT = 4'b0011,
    SDRBR_RD  = 4'b0101,
    SDRBR_WR  = 4'b0100,
    SDRBR_PRE = 4'b0010,
    SDRBR_REF = 4'b0001,
    SDRBR_MRS = 4'b0000,
    SDRBR_DES = 4'b1111
  } sdrbr_cmd_t;
  // per-bank state
  typedef enum logic [1:0] {
    SDRBR_IDLE   = 2'b00,
    SDRBR_ACTIVE = 2'b01,
    SDRBR_PRECH  = 2'b10
  } sdrbr_bank_t;
  // sequencer state
  typedef enum logic [2:0] {
    SDRBR_S_RUN     = 3'b000,
    SDRBR_S_WL_REL  = 3'b001,
    SDRBR_S_WL_ODT  = 3'b010,
    SDRBR_S_WL_MRS  = 3'b011,
    SDRBR_S_WAIT    = 3'b100
  } sdrbr_seq_t;
endpackage

// >>> verilog/sdrbr_bank.sv
// one bank tracker: idle, active with a row, or precharging
`timescale 1ns/1ps
`include "sdrbr_map.svh"
module sdrbr_bank (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 do_act,
  input  wire logic                 do_pre,
  input  wire logic                 do_ref,
  input  wire logic [14:0]          row_in,
  output sdrbr_pkg::sdrbr_bank_t    state,
  output logic      [14:0]          open_row,
  output logic                      ready
);
  localparam logic [7:0] TRP = 8'(`SDRBR_CYC_UP(`SDRBR_TRP_NS));
  localparam logic [7:0] TRFC = 8'(`SDRBR_CYC_UP(`SDRBR_TRFC_NS));
  logic [7:0] wait_cnt;

  // state and row register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= sdrbr_pkg::SDRBR_IDLE;
      open_row <= 15'h0000;
    end else if (do_ref) begin
      state <= sdrbr_pkg::SDRBR_IDLE;
    end else if (do_act) begin
      state    <= sdrbr_pkg::SDRBR_ACTIVE;
      open_row <= row_in;
    end else if (do_pre) begin
      state <= sdrbr_pkg::SDRBR_PRECH;
    end else if (state == sdrbr_pkg::SDRBR_PRECH && wait_cnt == 8'h00) begin
      state <= sdrbr_pkg::SDRBR_IDLE;
    end
  end

  // recovery timer restarts on each precharge, so the last one rules
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 8'h00;
    end else if (do_ref) begin
      wait_cnt <= TRFC - 8'h01;
    end else if (do_pre) begin
      wait_cnt <= TRP - 8'h01;
    end else if (wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end

  // timer only: the strobes this flag helps to gate must never loop back into it
  assign ready = (wait_cnt == 8'h00);
endmodule // sdrbr_bank

// >>> verilog/sdrbr_ctrl.sv
// controller that drives the sdram command bus, refresh and leveling exit
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "sdrbr_map.svh"
module sdrbr_ctrl #(
  parameter int unsigned REFI_CYC = `SDRBR_CYC_DN(`SDRBR_TREFI_NS)
) (
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             CS_N,
  output logic             RAS_N,
  output logic             CAS_N,
  output logic             WE_N,
  output logic      [2:0]  BA,
  output logic      [14:0] A,
  output logic             ODT,
  output logic             DQS_OE,
  output logic             RD_VALID,
  output logic             BUSY
);
  localparam logic [7:0] TMRD = 8'(`SDRBR_TMRD_CK);
  localparam logic [7:0] TMOD = 8'(`SDRBR_TMOD_CK);
  localparam logic [7:0] TIS  = 8'(`SDRBR_TIS_CK);
  localparam logic [7:0] TCCD = 8'(`SDRBR_TCCD_CK);
  localparam logic [7:0] TRFC = 8'(`SDRBR_CYC_UP(`SDRBR_TRFC_NS));
  localparam logic [31:0] REFI = 32'(REFI_CYC);

  logic       rst_s1;
  logic       rst_n;
  logic [31:0] ctrl;
  logic [3:0]  cmd_op;
  logic [2:0]  cmd_ba;
  logic        cmd_all;
  logic [14:0] cmd_addr;
  logic        cmd_go;
  logic        illegal;
  logic        reject;
  sdrbr_pkg::sdrbr_seq_t seq;
  logic [7:0]  seq_cnt;
  logic [7:0]  mrd_cnt;
  logic [7:0]  ccd_cnt;
  logic [31:0] refi_cnt;
  logic signed [4:0] ref_debt;
  logic [31:0] rd_pipe;
  logic [4:0]  rd_lat;
  logic        rd_pend;
  logic        burst8;
  sdrbr_pkg::sdrbr_bank_t bank_state [8];
  logic [14:0] bank_row [8];
  logic [7:0]  bank_ready;
  logic [7:0]  act_v;
  logic [7:0]  pre_v;
  logic        ref_go;
  logic        issue;
  logic        all_idle;
  sdrbr_pkg::sdrbr_cmd_t next_cmd;

  // reset release through two flops
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // eight-beat decision from burst field and address bit twelve
  function automatic logic is_burst8(input logic [1:0] fld, input logic a12);
    is_burst8 = (fld == 2'b00) || (fld == 2'b01 && a12);
  endfunction

  // software control writes
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `SDRBR_CTRL_RESET;
    end else if (WR && ADDR == `SDRBR_REG_CTRL) begin
      ctrl <= WDATA;
    end else if (seq == sdrbr_pkg::SDRBR_S_WL_MRS) begin
      ctrl[`SDRBR_CTRL_WLEXIT] <= 1'b0;
    end
  end

  // command staging: op, bank, address; issue pulses one cycle
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_op   <= 4'h7;
      cmd_ba   <= 3'h0;
      cmd_all  <= 1'b0;
      cmd_addr <= 15'h0000;
      cmd_go   <= 1'b0;
    end else begin
      cmd_go <= WR && ADDR == `SDRBR_REG_CMD;
      if (WR && ADDR == `SDRBR_REG_ADDR) begin
        cmd_addr <= WDATA[14:0];
      end
      if (WR && ADDR == `SDRBR_REG_CMD) begin
        cmd_op  <= WDATA[3:0];
        cmd_ba  <= WDATA[6:4];
        cmd_all <= WDATA[8];
      end
    end
  end

  // every bank closed and past its recovery time; an open bank has no timer running
  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (bank_state[i] != sdrbr_pkg::SDRBR_IDLE || !bank_ready[i]) begin
        all_idle = 1'b0;
      end
    end
  end

  // legality check against bank states and timers
  always_comb begin
    illegal = 1'b0;
    unique case (cmd_op)
      4'b0011: illegal = bank_state[cmd_ba] != sdrbr_pkg::SDRBR_IDLE
                         || !bank_ready[cmd_ba];
      4'b0101, 4'b0100: illegal = bank_state[cmd_ba] != sdrbr_pkg::SDRBR_ACTIVE
                                  || ccd_cnt != 8'h00;
      4'b0010: illegal = 1'b0;
      4'b0001: illegal = 1'b0;
      4'b0000: illegal = mrd_cnt != 8'h00;
      default: illegal = 1'b1;
    endcase
  end

  // refresh goes when due and all banks idle with precharge time met, but a pending command strobe holds it off
  assign ref_go = ctrl[`SDRBR_CTRL_REFEN] && seq == sdrbr_pkg::SDRBR_S_RUN
                  && all_idle && ref_debt > 5'sd0 && !cmd_go;
  assign issue  = cmd_go && seq == sdrbr_pkg::SDRBR_S_RUN && !illegal
                  && (cmd_op != 4'b0001 || all_idle);
  assign reject = cmd_go && !issue;

  // per-bank strobes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      act_v[i] = issue && cmd_op == 4'b0011 && cmd_ba == 3'(i);
      pre_v[i] = issue && cmd_op == 4'b0010 && (cmd_all || cmd_ba == 3'(i));
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_bank
    sdrbr_bank u_bank (
      .clk      (CLOCK),
      .rst_n    (rst_n),
      .do_act   (act_v[g]),
      .do_pre   (pre_v[g]),
      .do_ref   (ref_go || (issue && cmd_op == 4'b0001)),
      .row_in   (cmd_addr),
      .state    (bank_state[g]),
      .open_row (bank_row[g]),
      .ready    (bank_ready[g])
    );
  end

  // refresh debt: +1 per interval, -1 per refresh, clamped both ways
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      refi_cnt <= 32'h0000_0000;
      ref_debt <= 5'sd0;
    end else begin
      refi_cnt <= (refi_cnt >= REFI - 32'h1) ? 32'h0 : refi_cnt + 32'h1;
      if ((ref_go || (issue && cmd_op == 4'b0001)) && refi_cnt != REFI - 32'h1) begin
        if (ref_debt > -5'sd8) begin
          ref_debt <= ref_debt - 5'sd1;
        end
      end else if (!(ref_go || (issue && cmd_op == 4'b0001))
                   && refi_cnt == REFI - 32'h1 && ref_debt < 5'sd9) begin
        ref_debt <= ref_debt + 5'sd1;
      end
    end
  end

  // leveling exit sequencer and post-refresh quiet time
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      seq     <= sdrbr_pkg::SDRBR_S_RUN;
      seq_cnt <= 8'h00;
    end else begin
      unique case (seq)
        sdrbr_pkg::SDRBR_S_RUN: begin
          if (ref_go || (issue && cmd_op == 4'b0001)) begin
            seq     <= sdrbr_pkg::SDRBR_S_WAIT;
            seq_cnt <= TRFC - 8'h01;
          end else if (issue && cmd_op == 4'b0000) begin
            seq     <= sdrbr_pkg::SDRBR_S_WAIT;
            seq_cnt <= TMOD - 8'h01;
          end else if (ctrl[`SDRBR_CTRL_WLEXIT]) begin
            seq <= sdrbr_pkg::SDRBR_S_WL_REL;
          end
        end
        sdrbr_pkg::SDRBR_S_WL_REL: begin
          seq     <= sdrbr_pkg::SDRBR_S_WL_ODT;
          seq_cnt <= TIS;
        end
        sdrbr_pkg::SDRBR_S_WL_ODT: begin
          if (seq_cnt == 8'h00) begin
            seq <= sdrbr_pkg::SDRBR_S_WL_MRS;
          end else begin
            seq_cnt <= seq_cnt - 8'h01;
          end
        end
        sdrbr_pkg::SDRBR_S_WL_MRS: begin
          seq     <= sdrbr_pkg::SDRBR_S_WAIT;
          seq_cnt <= TMOD - 8'h01;
        end
        sdrbr_pkg::SDRBR_S_WAIT: begin
          if (seq_cnt == 8'h00) begin
            seq <= sdrbr_pkg::SDRBR_S_RUN;
          end else begin
            seq_cnt <= seq_cnt - 8'h01;
          end
        end
        default: seq <= sdrbr_pkg::SDRBR_S_RUN;
      endcase
    end
  end

  // mode-register gap and column-to-column gap
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      mrd_cnt <= 8'h00;
      ccd_cnt <= 8'h00;
    end else begin
      if (seq == sdrbr_pkg::SDRBR_S_WL_MRS || (issue && cmd_op == 4'b0000)) begin
        mrd_cnt <= TMRD - 8'h01;
      end else if (mrd_cnt != 8'h00) begin
        mrd_cnt <= mrd_cnt - 8'h01;
      end
      if (issue && (cmd_op == 4'b0101 || cmd_op == 4'b0100)) begin
        ccd_cnt <= TCCD - 8'h01;
      end else if (ccd_cnt != 8'h00) begin
        ccd_cnt <= ccd_cnt - 8'h01;
      end
    end
  end

  // read latency tracker: one bit per read walks up the pipe, so reads closer
  // together than the latency each keep their own valid mark at al + cl
  assign rd_lat  = 5'(ctrl[`SDRBR_CTRL_AL_LO +: 4]) + 5'(ctrl[`SDRBR_CTRL_CL_LO +: 4]);
  assign rd_pend = |(rd_pipe & ~(32'hffff_ffff << rd_lat));

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rd_pipe  <= 32'h0000_0000;
      RD_VALID <= 1'b0;
      burst8   <= 1'b0;
    end else begin
      rd_pipe  <= {rd_pipe[30:0], issue && cmd_op == 4'b0101};
      RD_VALID <= rd_pipe[rd_lat - 5'h01];
      if (issue && cmd_op == 4'b0101) begin
        burst8  <= is_burst8(ctrl[`SDRBR_CTRL_BLF_LO +: 2], cmd_addr[`SDRBR_ADDR_BURST]);
      end
    end
  end

  // pin drive: command, bank, address, termination, strobe enable
  always_comb begin
    next_cmd = sdrbr_pkg::SDRBR_NOP;
    if (seq == sdrbr_pkg::SDRBR_S_WL_MRS) begin
      next_cmd = sdrbr_pkg::SDRBR_MRS;
    end else if (ref_go) begin
      next_cmd = sdrbr_pkg::SDRBR_REF;
    end else if (issue) begin
      next_cmd = sdrbr_pkg::sdrbr_cmd_t'(cmd_op);
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      {CS_N, RAS_N, CAS_N, WE_N} <= 4'h7;
      BA     <= 3'h0;
      A      <= 15'h0000;
      ODT    <= 1'b0;
      DQS_OE <= 1'b0;
    end else begin
      {CS_N, RAS_N, CAS_N, WE_N} <= next_cmd;
      if (seq == sdrbr_pkg::SDRBR_S_WL_MRS) begin
        BA <= 3'h1;
        A  <= cmd_addr & ~(15'h0001 << `SDRBR_MR1_LEVEL);
      end else if (next_cmd == sdrbr_pkg::SDRBR_REF) begin
        A <= 15'h0000;
      end else if (issue) begin
        BA <= cmd_ba;
        // a10 means all banks on precharge; reads and writes keep auto precharge off,
        // since the bank trackers would never see such a bank close
        if (cmd_op == 4'b0010 || cmd_op == 4'b0101 || cmd_op == 4'b0100) begin
          A <= {cmd_addr[14:11], cmd_all && cmd_op == 4'b0010, cmd_addr[9:0]};
        end else begin
          A <= cmd_addr;
        end
      end
      if (seq != sdrbr_pkg::SDRBR_S_RUN) begin
        ODT <= 1'b0;
      end
      DQS_OE <= 1'b0;
    end
  end

  // register read port and busy flag
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h0000_0000;
      BUSY  <= 1'b0;
    end else begin
      BUSY <= seq != sdrbr_pkg::SDRBR_S_RUN;
      RDATA <= 32'h0000_0000;
      if (RD) begin
        unique case (ADDR)
          `SDRBR_REG_CTRL:   RDATA <= ctrl;
          `SDRBR_REG_ADDR:   RDATA <= {17'h0, cmd_addr};
          `SDRBR_REG_STATUS: RDATA <= {24'h0, reject, burst8, rd_pend, 2'b0, seq};
          `SDRBR_REG_BANKS:  RDATA <= {bank_ready, 8'h0, bank_state[7], bank_state[6],
                                       bank_state[5], bank_state[4], bank_state[3],
                                       bank_state[2], bank_state[1], bank_state[0]};
          `SDRBR_REG_REFCNT: RDATA <= {27'h0, ref_debt};
          default:           RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
  // other banks stay usable; write faults need no recovery here
endmodule // sdrbr_ctrl

// >>> testbench/sdrbr_dram.sv
// behavioural sdram device watching the controller's command pins
`timescale 1ns/1ps
module sdrbr_dram (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [14:0] a,
  output logic      [15:0] errs,
  output logic      [15:0] refs,
  output logic      [14:0] last_row
);
  sdrbr_pkg::sdrbr_bank_t st [8];
  logic [15:0] rc;
  logic        lvl;
  logic        chop;
  logic [3:0]  c;
  assign c = {cs_n, ras_n, cas_n, we_n};
  // one command per rising edge; errs counts commands the bank state or write leveling forbids
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errs <= 16'h0000;
      refs <= 16'h0000;
      rc <= 16'h0000;
      lvl <= 1'b0;
      chop <= 1'b0;
      last_row <= 15'h0000;
      for (int i = 0; i < 8; i++) st[i] <= sdrbr_pkg::SDRBR_IDLE;
    end else begin
      case (c)
        sdrbr_pkg::SDRBR_ACT: begin
          if (st[ba] == sdrbr_pkg::SDRBR_ACTIVE || lvl) errs <= errs + 16'h0001;
          st[ba] <= sdrbr_pkg::SDRBR_ACTIVE;
          last_row <= a;
        end
        sdrbr_pkg::SDRBR_PRE: begin
          // idle banks accept it too, nothing to time here
          for (int i = 0; i < 8; i++) if (a[10] || ba == 3'(i)) st[i] <= sdrbr_pkg::SDRBR_IDLE;
        end
        sdrbr_pkg::SDRBR_RD, sdrbr_pkg::SDRBR_WR: begin
          if (st[ba] != sdrbr_pkg::SDRBR_ACTIVE || lvl) errs <= errs + 16'h0001;
          chop <= !a[12];
        end
        sdrbr_pkg::SDRBR_REF: begin
          for (int i = 0; i < 8; i++) if (st[i] != sdrbr_pkg::SDRBR_IDLE) errs <= errs + 16'h0001;
          refs <= refs + 16'h0001;
          rc <= rc + 16'h0001;
        end
        sdrbr_pkg::SDRBR_MRS: if (ba == 3'h1) lvl <= a[7];
        default: ;
      endcase
    end
  end
endmodule // sdrbr_dram

// >>> testbench/sdrbr_chk.sv
// assertions on the controller's software port and command pins
`timescale 1ns/1ps
`include "sdrbr_map.svh"
module sdrbr_chk #(
  parameter int unsigned REFI_CYC = 975
) (
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        CS_N,
  input wire logic        RAS_N,
  input wire logic        CAS_N,
  input wire logic        WE_N,
  input wire logic [2:0]  BA,
  input wire logic [14:0] A,
  input wire logic        ODT,
  input wire logic        DQS_OE,
  input wire logic        RD_VALID,
  input wire logic        BUSY
);
  logic [3:0]  c;
  logic        q, act, pre, rdw, rf, mrs;
  logic [7:0]  opn, pg, mg, cg;
  logic [15:0] rg, ig;
  logic [11:0] ctl;
  logic [31:0] rp;
  assign c = {CS_N, RAS_N, CAS_N, WE_N};
  assign q = CS_N || c == sdrbr_pkg::SDRBR_NOP;
  assign act = c == sdrbr_pkg::SDRBR_ACT;
  assign pre = c == sdrbr_pkg::SDRBR_PRE;
  assign rdw = c == sdrbr_pkg::SDRBR_RD || c == sdrbr_pkg::SDRBR_WR;
  assign rf = c == sdrbr_pkg::SDRBR_REF;
  assign mrs = c == sdrbr_pkg::SDRBR_MRS;
  // saturating distances; reset saturated so nothing fires just after reset
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pg <= 8'hff;
      mg <= 8'hff;
      cg <= 8'hff;
      rg <= 16'hffff;
    end else begin
      pg <= pre ? 8'h01 : pg + 8'(pg != 8'hff);
      mg <= mrs ? 8'h01 : mg + 8'(mg != 8'hff);
      cg <= rdw ? 8'h01 : cg + 8'(cg != 8'hff);
      rg <= rf ? 16'h0001 : rg + 16'(rg != 16'hffff);
    end
  end
  // refresh interval counts only while refresh is enabled
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) ig <= 16'h0000;
    else ig <= (rf || !ctl[0]) ? 16'h0000 : ig + 16'h0001;
  end
  // control mirror, open banks and issued reads
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctl <= 12'h500;
      opn <= 8'h00;
      rp <= 32'h0;
    end else begin
      if (WR && ADDR == `SDRBR_REG_CTRL) ctl <= WDATA[11:0];
      if (act) opn[BA] <= 1'b1;
      if (pre) opn <= A[10] ? 8'h00 : opn & ~(8'h01 << BA);
      rp <= {rp[30:0], c == sdrbr_pkg::SDRBR_RD};
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence bus_quiet;
    q [*8];
  endsequence
  ref_quiet_a: assert property (rf |=> bus_quiet) else $error("command in refresh");
  ref_cycle_a: assert property (!q |-> rg >= 16'h0021) else $error("refresh cycle short");
  ref_idle_a: assert property (rf |-> opn == 8'h00 && pg >= 8'h02) else $error("refresh busy");
  act_closed_a: assert property (act |-> !opn[BA] && pg >= 8'h02) else $error("bad activate");
  access_open_a: assert property (rdw |-> opn[BA]) else $error("access to idle bank");
  col_gap_a: assert property (rdw |-> cg >= 8'h04) else $error("column gap short");
  mrs_gap_a: assert property (mrs |-> mg >= 8'h04) else $error("mode gap short");
  mod_wait_a: assert property (!q && !mrs |-> mg >= 8'h0c) else $error("mode update short");
  read_lat_a: assert property (RD_VALID == rp[ctl[7:4] + ctl[11:8] - 1]) else $error("latency");
  odt_low_a: assert property (!ODT) else $error("termination driven");
  dqs_free_a: assert property (!DQS_OE) else $error("strobes driven");
  exit_mrs_a: assert property (mrs && BUSY |-> BA == 3'h1 && !A[7]) else $error("exit mrs");
  ref_int_a: assert property (ig <= 9 * REFI_CYC) else $error("refresh overdue");
endmodule // sdrbr_chk
bind sdrbr_ctrl sdrbr_chk #(.REFI_CYC(REFI_CYC)) chk_u (
  .CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .CS_N(CS_N),
  .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .A(A), .ODT(ODT),
  .DQS_OE(DQS_OE), .RD_VALID(RD_VALID), .BUSY(BUSY)
);

// >>> testbench/tb.sv
// self-checking bench for the sdram controller
`timescale 1ns/1ps
`include "sdrbr_map.svh"
module tb;
  localparam int unsigned REFI = 50;
  logic        clock, nrst, wr, rd, cs_n, ras_n, cas_n, we_n, odt, dqs_oe, rd_valid, busy;
  logic [3:0]  addr, cmd;
  logic [31:0] wdata, rdata, got;
  logic [2:0]  ba;
  logic [14:0] a, last_row;
  logic [15:0] errs, refs;
  logic [7:0]  open_b;
  int          bad_count, compares, seed, n, k;
  sdrbr_pkg::sdrbr_cmd_t ops [4] = '{sdrbr_pkg::SDRBR_ACT, sdrbr_pkg::SDRBR_RD,
                                     sdrbr_pkg::SDRBR_WR, sdrbr_pkg::SDRBR_PRE};
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  sdrbr_ctrl #(.REFI_CYC(REFI)) dut_u (
    .CLOCK(clock), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
    .BA(ba), .A(a), .ODT(odt), .DQS_OE(dqs_oe), .RD_VALID(rd_valid), .BUSY(busy)
  );
  sdrbr_dram dev_u (
    .clk(clock), .rst_n(nrst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .a(a), .errs(errs), .refs(refs), .last_row(last_row)
  );
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] r, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= r;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] r);
    @(posedge clock);
    rd <= 1'b1;
    addr <= r;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic wait_for(input logic [3:0] c);
    n = 0;
    while (cmd !== c && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
  endtask
  // pins expected for a command, judged from the banks the bench has opened
  function automatic logic [3:0] expect_cmd(input logic [3:0] op, input logic [2:0] b);
    if (op == sdrbr_pkg::SDRBR_PRE) return op;
    if (op == sdrbr_pkg::SDRBR_ACT) return open_b[b] ? sdrbr_pkg::SDRBR_NOP : op;
    return open_b[b] ? op : sdrbr_pkg::SDRBR_NOP;
  endfunction
  // address then command word; pins show it two edges after the strobe
  task automatic issue(input logic [3:0] op, input logic [2:0] b, input logic [14:0] v,
                       input logic all);
    logic [3:0] e;
    e = expect_cmd(op, b);
    wr_reg(`SDRBR_REG_ADDR, {17'h0, v});
    wr_reg(`SDRBR_REG_CMD, {23'h0, all, 1'b0, b, op});
    @(posedge clock);
    #1 chk({28'h0, cmd}, {28'h0, e}, "command pins");
    if (e == sdrbr_pkg::SDRBR_ACT) begin
      chk({14'h0, ba, a}, {14'h0, b, v}, "bank and row");
      open_b[b] = 1'b1;
    end
    if (e == sdrbr_pkg::SDRBR_PRE) begin
      chk({31'h0, a[10]}, {31'h0, all}, "all banks");
      open_b = all ? 8'h00 : open_b & ~(8'h01 << b);
    end
    if (e == sdrbr_pkg::SDRBR_RD || e == sdrbr_pkg::SDRBR_WR)
      chk({31'h0, a[12]}, {31'h0, v[12]}, "burst bit");
  endtask
  initial begin
    seed = 69295;
    {wr, rd, addr, wdata, open_b} = '0;
    bad_count = 0;
    compares = 0;
    nrst = 1'b0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    wr_reg(4'hf, 32'hffff_ffff);
    rd_reg(`SDRBR_REG_CTRL);
    chk(got, `SDRBR_CTRL_RESET, "control reset");
    $display("test reset done");
    n = $random(seed);
    issue(sdrbr_pkg::SDRBR_ACT, 3'h2, n[14:0], 1'b0);
    issue(sdrbr_pkg::SDRBR_ACT, 3'h2, 15'h0123, 1'b0);
    issue(sdrbr_pkg::SDRBR_RD, 3'h5, 15'h0010, 1'b0);
    issue(sdrbr_pkg::SDRBR_PRE, 3'h6, 15'h0000, 1'b0);
    issue(sdrbr_pkg::SDRBR_PRE, 3'h6, 15'h0000, 1'b0);
    // second read three cycles behind the first falls inside the column gap
    wr_reg(`SDRBR_REG_CMD, {25'h0, 3'h2, sdrbr_pkg::SDRBR_RD});
    @(posedge clock);
    #1 chk({28'h0, cmd}, {28'h0, sdrbr_pkg::SDRBR_RD}, "first read");
    wr_reg(`SDRBR_REG_CMD, {25'h0, 3'h2, sdrbr_pkg::SDRBR_RD});
    @(posedge clock);
    #1 chk({28'h0, cmd}, {28'h0, sdrbr_pkg::SDRBR_NOP}, "close read");
    // burst field fixed or on the fly, additive latency 0 or 4
    for (k = 0; k < 4; k++) begin
      repeat (8) @(posedge clock);
      wr_reg(`SDRBR_REG_CTRL, `SDRBR_CTRL_RESET | (32'(k[1]) << 12) | (32'(k[1]) << 6));
      issue(sdrbr_pkg::SDRBR_RD, 3'h2, {2'b0, k[0], 12'h0a0}, 1'b0);
      n = 0;
      while (rd_valid !== 1'b1 && n < 20) begin
        @(posedge clock);
        #1 n++;
      end
      chk(n, 5 + 4 * k[1], "read latency");
      rd_reg(`SDRBR_REG_STATUS);
      chk({31'h0, got[6]}, {31'h0, k[1] == 0 || k[0]}, "eight beats");
    end
    wr_reg(`SDRBR_REG_CTRL, `SDRBR_CTRL_RESET);
    $display("test corners done");
    // wide spacing keeps every refusal down to bank state alone
    for (k = 0; k < 40; k++) begin
      n = $random(seed);
      issue(ops[n[1:0]], n[4:2], n[19:5], n[20] && n[21]);
      repeat (14) @(posedge clock);
    end
    issue(sdrbr_pkg::SDRBR_PRE, 3'h0, 15'h0000, 1'b1);
    $display("test random done");
    got = {16'h0, refs};
    wr_reg(`SDRBR_REG_CTRL, `SDRBR_CTRL_RESET | 32'h1);
    wait_for(sdrbr_pkg::SDRBR_REF);
    @(posedge clock);
    #1 chk({31'h0, busy}, 32'h1, "busy after refresh");
    wr_reg(`SDRBR_REG_CMD, {25'h0, 3'h1, sdrbr_pkg::SDRBR_ACT});
    @(posedge clock);
    #1 chk({28'h0, cmd}, {28'h0, sdrbr_pkg::SDRBR_NOP}, "act in refresh");
    repeat (4 * REFI) @(posedge clock);
    #1 chk({31'h0, refs - got[15:0] >= 16'h0003}, 32'h1, "refresh count");
    wr_reg(`SDRBR_REG_CTRL, `SDRBR_CTRL_RESET);
    repeat (60) @(posedge clock);
    $display("test refresh done");
    wr_reg(`SDRBR_REG_ADDR, 32'h0000_0084);
    wr_reg(`SDRBR_REG_CTRL, `SDRBR_CTRL_RESET | 32'h2);
    wait_for(sdrbr_pkg::SDRBR_MRS);
    chk({14'h0, ba, a}, {14'h0, 3'h1, 15'h0004}, "exit mode word");
    chk({30'h0, odt, dqs_oe}, 32'h0, "strobes and odt");
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clock);
      #1 n++;
    end
    chk({31'h0, n >= `SDRBR_TMOD_CK && n < 100}, 32'h1, "mode update wait");
    wr_reg(`SDRBR_REG_CTRL, `SDRBR_CTRL_RESET);
    $display("test leveling exit done");
    chk({16'h0, errs}, 32'h0, "device saw illegal command");
    wrap_up();
  end
  // run needs about 1200 cycles; this limit of 50000 cycles is some forty times that
  initial begin
    #400000;
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
endmodule // tb
